// *** rps_cfg.svh ***
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH
// register byte offsets
`define RPS_OFF_CTRL     8'h00
`define RPS_OFF_UPDATE   8'h04
`define RPS_OFF_RAMADDR  8'h08
`define RPS_OFF_RAMDATA  8'h0c
`define RPS_OFF_STATUS   8'h10
`define RPS_OFF_PROF     8'h40
`define RPS_PROF_TOP     8'h7c
// control fields
`define RPS_CTRL_RAMEN   0
`define RPS_CTRL_MODE    3:1
`define RPS_CTRL_DEST    5:4
`define RPS_CTRL_NODWELL 6
`define RPS_CTRL_RST     7'h00
// profile word fields (word 0 / word 1)
`define RPS_PW_RATE      15:0
`define RPS_PW_START     9:0
`define RPS_PW_END       25:16
`define RPS_PW_PHASE     15:0
`define RPS_PW_AMP       29:16
// ram data to destination slices
`define RPS_RD_PHASE     31:16
`define RPS_RD_AMP       31:18
`define RPS_RD_PAMP      15:2
// status fields
`define RPS_ST_ADDR      9:0
`define RPS_ST_SWEEP     12
`define RPS_ST_PROF      18:16
// sizes and counts
`define RPS_AW           10
`define RPS_SWEEP_PULSE  2'd2
`define RPS_SYNC_DIV     2'd3
`define RPS_RESP_OKAY    2'b00
`define RPS_RESP_SLVERR  2'b10
`endif

// *** rps_pkg.sv ***
package rps_pkg;
	typedef enum logic [2:0] {
		RPS_MODE_IDLE   = 3'b000,
		RPS_MODE_BIDIR  = 3'b001,
		RPS_MODE_CBIDIR = 3'b010,
		RPS_MODE_RECIRC = 3'b011
	} rps_mode_t;
	typedef enum logic [1:0] {
		RPS_DEST_FREQ  = 2'b00,
		RPS_DEST_PHASE = 2'b01,
		RPS_DEST_AMP   = 2'b10,
		RPS_DEST_POLAR = 2'b11
	} rps_dest_t;
endpackage

// *** rps_sync_div.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"
module rps_sync_div
	import rps_pkg::*;
(
	input  wire logic aclk,     // system clock
	input  wire logic aresetn,  // sync reset, low
	output logic      sync_clk, // system clock / 4
	output logic      tick      // one cycle, at sync_clk rise
);
	typedef struct packed {
		logic [1:0] cnt;
		logic       clk;
		logic       tick;
	} rps_div_t;
	rps_div_t s_ff, nxt_s;
	// divide by four; tick marks the cycle in which sync_clk goes high
	always_comb begin
		nxt_s = s_ff;
		nxt_s.cnt = s_ff.cnt + 2'd1;
		// decode the next count so the first high phase after reset is full width
		nxt_s.clk = (nxt_s.cnt == `RPS_SYNC_DIV) || (nxt_s.cnt == 2'd0);
		nxt_s.tick = (nxt_s.cnt == `RPS_SYNC_DIV);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	assign sync_clk = s_ff.clk;
	assign tick = s_ff.tick;
endmodule
`default_nettype wire

// *** rps_step_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"
module rps_step_timer
	import rps_pkg::*;
(
	input  wire logic        aclk,    // system clock
	input  wire logic        aresetn, // sync reset, low
	input  wire logic        load,    // restart the interval
	input  wire logic [15:0] rate,    // cycles per step minus one
	output logic             expire   // one-cycle step pulse
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        exp;
	} rps_tmr_t;
	rps_tmr_t s_ff, nxt_s;
	// down-counter reloaded from the ramp rate, one pulse per expiry
	always_comb begin
		nxt_s = s_ff;
		nxt_s.exp = 1'b0;
		if (load) begin
			nxt_s.cnt = rate;
		end else if (s_ff.cnt == 16'h0000) begin
			nxt_s.cnt = rate;
			nxt_s.exp = 1'b1;
		end else begin
			nxt_s.cnt = s_ff.cnt - 16'h0001;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	assign expire = s_ff.exp;
endmodule
`default_nettype wire

// *** rps_top.sv ***
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"
// Summary of operation
// - bidirectional mode takes start, end and rate from profile 0 only.
// - bidirectional mode ignores profile pins 2 and 1; no other profile selectable.
// - no-dwell-high setting has no effect in these three playback modes.
// - bidirectional: hold at start; bit 0 high counts up to end, halts.
// - bidirectional: bit 0 low counts down to start, halts there.
// - bit 0 change mid-ramp restarts step timer and reverses direction.
// - bidirectional sweep flag set at end; cleared at start on bit 0 rise.
// - activation loads start address and clears the sweep flag.
// - continuous bidirectional uses pin profile, bouncing between terminal addresses forever.
// - continuous bidirectional: pin change aborts and restarts with new profile.
// - continuous bidirectional: flag cleared on activation, high at end, low at start.
// - recirculate counts up; expiry after end reloads start, repeating.
// - recirculate: pin change aborts, restarting from new profile's start.
// - recirculate: flag low on activation, two-cycle pulse at each end.
// - three profile pins decode as binary profile number zero to seven.
// - ram enable low means single-tone profile format, high RAM format.
// - each RAM word goes to parameters chosen by destination setting.
// - address steps once per ramp-rate interval between start and end.
// - sync clock is system clock divided by four, rising edge active.
module rps_top
	import rps_pkg::*;
(
	input  wire logic        aclk,            // 10 MHz system clock
	input  wire logic        aresetn,         // sync reset, low
	input  wire logic [31:0] s_axi_awaddr,    // write address
	input  wire logic        s_axi_awvalid,   // write address valid
	output logic             s_axi_awready,   // write address ready
	input  wire logic [31:0] s_axi_wdata,     // write data
	input  wire logic [3:0]  s_axi_wstrb,     // byte enables
	input  wire logic        s_axi_wvalid,    // write data valid
	output logic             s_axi_wready,    // write data ready
	output logic [1:0]       s_axi_bresp,     // write response
	output logic             s_axi_bvalid,    // write response valid
	input  wire logic        s_axi_bready,    // write response ready
	input  wire logic [31:0] s_axi_araddr,    // read address
	input  wire logic        s_axi_arvalid,   // read address valid
	output logic             s_axi_arready,   // read address ready
	output logic [31:0]      s_axi_rdata,     // read data
	output logic [1:0]       s_axi_rresp,     // read response
	output logic             s_axi_rvalid,    // read data valid
	input  wire logic        s_axi_rready,    // read data ready
	input  wire logic [2:0]  profile_select,  // profile pins, bit 0 is profile_select_bit0
	input  wire logic        io_update,       // update strobe pin, rising edge
	output logic             sync_clk,        // system clock / 4
	output logic             sweep_over_flag, // sweep-over pin
	output logic [9:0]       ram_addr,        // playback address
	output logic [31:0]      freq_word,       // synthesis_core frequency word
	output logic [15:0]      phase_word,      // synthesis_core phase offset
	output logic [13:0]      amp_word         // synthesis_core amplitude
);
	typedef struct packed {
		logic                       awready;
		logic                       wready;
		logic                       awv;
		logic [7:0]                 awaddr;
		logic                       awbad;
		logic                       wv;
		logic [31:0]                wdata;
		logic [3:0]                 wstrb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		logic [6:0]                 ctrl;
		logic [`RPS_AW-1:0]         ramaddr;
		logic [7:0][1:0][31:0]      prof;
		logic                       upd_prev;
		logic [2:0]                 prof_q;
		logic [2:0]                 act;
		rps_mode_t                  mode;
		logic                       run;
		logic [`RPS_AW-1:0]         addr;
		logic                       up;
		logic                       sweep;
		logic [1:0]                 pcnt;
		logic                       at_end;
		logic [31:0]                freq;
		logic [15:0]                phase;
		logic [13:0]                amp;
	} rps_state_t;

	rps_state_t        s_ff, nxt_s;
	logic [31:0]       ram_mem [0:(1<<`RPS_AW)-1];
	logic [31:0]       ram_q;
	logic              ram_we;
	logic [31:0]       ram_wd;
	logic              tick;
	logic              expire;
	logic              tmr_load;
	logic [15:0]       tmr_rate;

	// only the low byte decodes; anything above it is an unmapped address
	function automatic logic addr_ok(input logic [31:0] a);
		return (a[31:8] == 24'h000000) && (a[1:0] == 2'b00) &&
			(a[7:0] <= `RPS_OFF_STATUS || (a[7:0] >= `RPS_OFF_PROF && a[7:0] <= `RPS_PROF_TOP));
	endfunction

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] b);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (b[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		end
		return r;
	endfunction

	rps_sync_div u_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sync_clk (sync_clk),
		.tick     (tick)
	);

	rps_step_timer u_tmr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (tmr_load),
		.rate    (tmr_rate),
		.expire  (expire)
	);

	// waveform memory: written word by word from the bus, read every cycle
	always_ff @(posedge aclk) begin
		if (ram_we)
			ram_mem[s_ff.ramaddr] <= ram_wd;
		ram_q <= ram_mem[s_ff.addr];
	end

	// rate of the profile running from the next edge, so a restart times its first step right
	assign tmr_rate = s_ff.prof[nxt_s.act][0][`RPS_PW_RATE];

	always_comb begin
		logic              sw_upd;
		logic              act_ev;
		logic              pchg;
		logic              p0chg;
		logic [2:0]        nidx;
		rps_mode_t         cmode;
		logic [`RPS_AW-1:0] st;
		logic [`RPS_AW-1:0] en;
		logic [`RPS_AW-1:0] na;
		logic [31:0]       cw;
		sw_upd = 1'b0;
		act_ev = 1'b0;
		pchg = 1'b0;
		p0chg = 1'b0;
		nidx = 3'd0;
		cmode = rps_mode_t'(s_ff.ctrl[`RPS_CTRL_MODE]);
		st = '0;
		en = '0;
		na = s_ff.addr;
		cw = '0;
		nxt_s = s_ff;
		ram_we = 1'b0;
		ram_wd = s_ff.wdata;
		tmr_load = 1'b0;

		// bus: address and data are taken in either order
		if (s_ff.awready && s_axi_awvalid) begin
			nxt_s.awv = 1'b1;
			nxt_s.awaddr = s_axi_awaddr[7:0];
			nxt_s.awbad = !addr_ok(s_axi_awaddr);
		end
		if (s_ff.wready && s_axi_wvalid) begin
			nxt_s.wv = 1'b1;
			nxt_s.wdata = s_axi_wdata;
			nxt_s.wstrb = s_axi_wstrb;
		end
		if (s_ff.bvalid && s_axi_bready)
			nxt_s.bvalid = 1'b0;
		// write executes one cycle after both halves are held
		if (s_ff.awv && s_ff.wv && !s_ff.bvalid) begin
			nxt_s.awv = 1'b0;
			nxt_s.wv = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = s_ff.awbad ? `RPS_RESP_SLVERR : `RPS_RESP_OKAY;
			if (!s_ff.awbad) begin
				if (s_ff.awaddr == `RPS_OFF_CTRL) begin
					cw = merge({25'h0, s_ff.ctrl}, s_ff.wdata, s_ff.wstrb);
					nxt_s.ctrl = cw[6:0];
				end else if (s_ff.awaddr == `RPS_OFF_UPDATE)
					sw_upd = 1'b1;
				else if (s_ff.awaddr == `RPS_OFF_RAMADDR)
					nxt_s.ramaddr = s_ff.wdata[`RPS_AW-1:0];
				else if (s_ff.awaddr == `RPS_OFF_RAMDATA) begin
					// auto-increment so a table loads with back-to-back writes
					ram_we = 1'b1;
					nxt_s.ramaddr = s_ff.ramaddr + 10'h001;
				end else if (s_ff.awaddr >= `RPS_OFF_PROF)
					nxt_s.prof[s_ff.awaddr[5:3]][s_ff.awaddr[2]] =
						merge(s_ff.prof[s_ff.awaddr[5:3]][s_ff.awaddr[2]], s_ff.wdata, s_ff.wstrb);
			end
		end
		nxt_s.awready = !nxt_s.awv && !nxt_s.bvalid;
		nxt_s.wready = !nxt_s.wv && !nxt_s.bvalid;

		// bus read: one cycle from address to data
		if (s_ff.rvalid && s_axi_rready)
			nxt_s.rvalid = 1'b0;
		if (s_ff.arready && s_axi_arvalid) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = `RPS_RESP_OKAY;
			nxt_s.rdata = 32'h0000_0000;
			if (!addr_ok(s_axi_araddr))
				nxt_s.rresp = `RPS_RESP_SLVERR;
			else if (s_axi_araddr[7:0] == `RPS_OFF_CTRL)
				nxt_s.rdata = {25'h0, s_ff.ctrl};
			else if (s_axi_araddr[7:0] == `RPS_OFF_RAMADDR)
				nxt_s.rdata = {22'h0, s_ff.ramaddr};
			else if (s_axi_araddr[7:0] == `RPS_OFF_STATUS) begin
				nxt_s.rdata[`RPS_ST_ADDR] = s_ff.addr;
				nxt_s.rdata[`RPS_ST_SWEEP] = s_ff.sweep;
				// single tone reports the pin profile, playback the one latched at activation
				nxt_s.rdata[`RPS_ST_PROF] = s_ff.ctrl[`RPS_CTRL_RAMEN] ? s_ff.act : s_ff.prof_q;
			end else if (s_axi_araddr[7:0] >= `RPS_OFF_PROF)
				nxt_s.rdata = s_ff.prof[s_axi_araddr[5:3]][s_axi_araddr[2]];
		end
		nxt_s.arready = !nxt_s.rvalid;

		// pins sampled on the sync clock rising edge only
		if (tick)
			nxt_s.prof_q = profile_select;
		// pins read as binary profile number
		pchg = tick && (profile_select != s_ff.prof_q);
		p0chg = tick && (profile_select[0] != s_ff.prof_q[0]);
		nxt_s.upd_prev = io_update;

		// in bidirectional mode pin changes never re-activate
		act_ev = (io_update && !s_ff.upd_prev) || sw_upd ||
			(pchg && s_ff.run && s_ff.mode != RPS_MODE_BIDIR);
		// bidirectional mode always plays profile 0
		nidx = (cmode == RPS_MODE_BIDIR) ? 3'd0 : nxt_s.prof_q;

		if (act_ev) begin
			// load start address and clear the flag
			nxt_s.mode = cmode;
			nxt_s.act = nidx;
			nxt_s.run = s_ff.ctrl[`RPS_CTRL_RAMEN] && cmode != RPS_MODE_IDLE;
			nxt_s.addr = s_ff.prof[nidx][1][`RPS_PW_START];
			nxt_s.up = (cmode == RPS_MODE_BIDIR) ? nxt_s.prof_q[0] : 1'b1;
			nxt_s.sweep = 1'b0;
			nxt_s.pcnt = 2'd0;
			nxt_s.at_end = 1'b0;
			tmr_load = 1'b1;
		end else if (s_ff.run) begin
			st = s_ff.prof[s_ff.act][1][`RPS_PW_START];
			en = s_ff.prof[s_ff.act][1][`RPS_PW_END];
			// the no-dwell-high control bit is never consulted here
			case (s_ff.mode)
				RPS_MODE_BIDIR: begin
					if (p0chg) begin
						// restart timer, direction follows bit 0
						tmr_load = 1'b1;
						nxt_s.up = profile_select[0];
						// flag drops on rise of bit 0 at start
						if (profile_select[0] && s_ff.addr == st)
							nxt_s.sweep = 1'b0;
					end else if (expire) begin
						// climb while bit 0 high, halt at end
						if (s_ff.up && s_ff.addr != en)
							na = s_ff.addr + 10'h001;
						// fall while bit 0 low, halt at start
						else if (!s_ff.up && s_ff.addr != st)
							na = s_ff.addr - 10'h001;
						nxt_s.addr = na;
						if (s_ff.up && na == en)
							nxt_s.sweep = 1'b1;
					end
				end
				RPS_MODE_CBIDIR: begin
					if (expire) begin
						// bounce between the two terminal addresses
						if (s_ff.up)
							na = (s_ff.addr == en) ? s_ff.addr - 10'h001 : s_ff.addr + 10'h001;
						else
							na = (s_ff.addr == st) ? s_ff.addr + 10'h001 : s_ff.addr - 10'h001;
						if (st == en)
							na = st;
						nxt_s.addr = na;
						if (na == en)
							nxt_s.up = 1'b0;
						else if (na == st)
							nxt_s.up = 1'b1;
						// high at end, low at start
						if (na == en)
							nxt_s.sweep = 1'b1;
						else if (na == st)
							nxt_s.sweep = 1'b0;
					end
				end
				RPS_MODE_RECIRC: begin
					if (expire) begin
						if (s_ff.at_end) begin
							nxt_s.addr = st;
							nxt_s.at_end = (st == en);
						end else begin
							na = s_ff.addr + 10'h001;
							nxt_s.addr = na;
							if (na == en) begin
								nxt_s.at_end = 1'b1;
								nxt_s.pcnt = `RPS_SWEEP_PULSE;
								nxt_s.sweep = 1'b1;
							end
						end
					end
					if (s_ff.pcnt != 2'd0 && nxt_s.pcnt == s_ff.pcnt) begin
						nxt_s.pcnt = s_ff.pcnt - 2'd1;
						nxt_s.sweep = (s_ff.pcnt != 2'd1);
					end
				end
				default: begin
					nxt_s.run = 1'b0;
				end
			endcase
		end
		// continuous bidirectional restart comes through act_ev above
		// recirculate restart likewise uses the new profile start

		// single-tone format when ram enable is low
		if (!s_ff.ctrl[`RPS_CTRL_RAMEN]) begin
			nxt_s.freq = s_ff.prof[s_ff.prof_q][0];
			nxt_s.phase = s_ff.prof[s_ff.prof_q][1][`RPS_PW_PHASE];
			nxt_s.amp = s_ff.prof[s_ff.prof_q][1][`RPS_PW_AMP];
		end else if (s_ff.run) begin
			// route ram word by destination setting
			case (rps_dest_t'(s_ff.ctrl[`RPS_CTRL_DEST]))
				RPS_DEST_FREQ: nxt_s.freq = ram_q;
				RPS_DEST_PHASE: nxt_s.phase = ram_q[`RPS_RD_PHASE];
				RPS_DEST_AMP: nxt_s.amp = ram_q[`RPS_RD_AMP];
				RPS_DEST_POLAR: begin
					nxt_s.phase = ram_q[`RPS_RD_PHASE];
					nxt_s.amp = ram_q[`RPS_RD_PAMP];
				end
				default: nxt_s.freq = ram_q;
			endcase
		end
	end

	// single state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
			s_ff.ctrl <= `RPS_CTRL_RST;
			s_ff.mode <= RPS_MODE_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready = s_ff.wready;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rdata = s_ff.rdata;
	assign s_axi_rresp = s_ff.rresp;
	assign sweep_over_flag = s_ff.sweep;
	assign ram_addr = s_ff.addr;
	assign freq_word = s_ff.freq;
	assign phase_word = s_ff.phase;
	assign amp_word = s_ff.amp;
endmodule
`default_nettype wire

// *** rps_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"
module rps_checker
	import rps_pkg::*;
(
	input wire logic        aclk,            // system clock
	input wire logic        aresetn,         // sync reset, low
	input wire logic [31:0] s_axi_awaddr,    // write address
	input wire logic        s_axi_awvalid,   // aw valid
	input wire logic        s_axi_awready,   // aw ready
	input wire logic [31:0] s_axi_wdata,     // write data
	input wire logic        s_axi_wvalid,    // w valid
	input wire logic        s_axi_wready,    // w ready
	input wire logic        s_axi_bvalid,    // b valid
	input wire logic        s_axi_arvalid,   // ar valid
	input wire logic        s_axi_arready,   // ar ready
	input wire logic        s_axi_rvalid,    // r valid
	input wire logic [2:0]  profile_select,  // profile pins
	input wire logic        io_update,       // update strobe
	input wire logic        sync_clk,        // divided clock
	input wire logic        sweep_over_flag, // sweep pin
	input wire logic [9:0]  ram_addr         // playback address
);
	logic [6:0] pend_q;
	logic [2:0] mode_q;
	logic [3:0] age_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// mode armed by control writes, live from the next strobe; assumes both write halves land together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_q <= 7'h00;
			mode_q <= 3'h0;
			age_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr[7:0] == `RPS_OFF_CTRL)
				pend_q <= s_axi_wdata[6:0];
			if (io_update)
				mode_q <= pend_q[0] ? pend_q[3:1] : 3'h0;
			age_q <= io_update ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
		end
	end
	sequence sync_tail_s;
		sync_clk ##1 !sync_clk [*2] ##1 sync_clk;
	endsequence
	sequence pulse_tail_s;
		sweep_over_flag ##1 !sweep_over_flag;
	endsequence
	sync_period_a: assert property ($rose(sync_clk) |=> sync_tail_s) else $error("sync period wrong");
	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
	write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write late");
	resp_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready during resp");
	bidir_step_a: assert property (mode_q == RPS_MODE_BIDIR && age_q > 4'd6 && $changed(ram_addr)
		|-> ram_addr == $past(ram_addr) + 10'd1 || ram_addr == $past(ram_addr) - 10'd1) else $error("bidir jump");
	bidir_clear_a: assert property (mode_q == RPS_MODE_BIDIR && age_q > 4'd6 && $fell(sweep_over_flag)
		|-> profile_select[0]) else $error("sweep cleared early");
	// two cycle pulse
	// a strobe or pin change acting at the rise restarts playback and may cut the pulse short
	recirc_pulse_a: assert property (mode_q == RPS_MODE_RECIRC && $rose(sweep_over_flag)
		&& !io_update && profile_select == $past(profile_select, 4) |=> pulse_tail_s) else $error("pulse width wrong");
	act_clear_a: assert property ($rose(io_update) && pend_q[0] && pend_q[3:1] != 3'h0
		|-> ##[1:4] !sweep_over_flag) else $error("sweep not cleared");
endmodule
bind rps_top rps_checker rps_checker_inst (.*);
`default_nettype wire

// *** rps_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rps_ctrl_model
	import rps_pkg::*;
(
	input  wire logic       aclk,           // system clock
	input  wire logic       sync_clk,       // divided clock
	input  wire logic [2:0] want_prof,      // profile asked for
	input  wire logic       want_upd,       // strobe asked for
	output logic [2:0]      profile_select = 3'h0, // profile pins
	output logic            io_update = 1'b0       // update strobe
);
	logic sync_q = 1'b0;
	// move after sync rise
	// one cycle after the rise keeps each level steady a whole sync period
	always @(posedge aclk) begin
		sync_q <= sync_clk;
		if (sync_clk && !sync_q) begin
			profile_select <= want_prof;
			io_update <= want_upd;
		end
	end
endmodule
`default_nettype wire

// *** rps_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"
module rps_top_test
	import rps_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0, want_upd = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0]  profile_select, want_prof = 3'h0;
	logic        io_update, sync_clk, sweep_over_flag;
	logic [9:0]  ram_addr;
	logic [31:0] s_axi_rdata, freq_word, rd;
	logic [15:0] phase_word;
	logic [13:0] amp_word;
	int          fail_count = 0, total_checks = 0;
	rps_top rps_top_inst (.*);
	rps_ctrl_model rps_ctrl_model_inst (.*);
	// 10 MHz
	always #50 aclk = ~aclk;
	function automatic logic [31:0] ramw(input logic [9:0] a);
		return {6'h15, a, 6'h2a, a};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// both halves offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic prof(input logic [2:0] i, input logic [15:0] r, input logic [9:0] s, input logic [9:0] e);
		axw(`RPS_OFF_PROF + {2'h0, i, 3'h0}, {16'h0, r});
		axw(`RPS_OFF_PROF + {2'h0, i, 3'h4}, {6'h0, e, 6'h0, s});
	endtask
	// pin changes need a sync period to reach the model and one more to be sampled
	task automatic pins(input logic [2:0] p);
		want_prof <= p;
		repeat (10) @(posedge aclk);
	endtask
	task automatic upd();
		want_upd <= 1'b1;
		repeat (8) @(posedge aclk);
		want_upd <= 1'b0;
		repeat (10) @(posedge aclk);
	endtask
	task automatic wait_addr(input logic [9:0] a);
		int n;
		n = 0;
		while (ram_addr !== a && n < 300) begin
			@(posedge aclk);
			n++;
		end
		chk("ram_addr", {22'h0, ram_addr}, {22'h0, a});
	endtask
	task automatic t_regs();
		axr(`RPS_OFF_CTRL);
		chk("ctrl reset", rd, 32'h0);
		axr(8'h20);
		chk("rresp", {30'h0, rsp}, {30'h0, `RPS_RESP_SLVERR});
		chk("rdata", rd, 32'h0);
		axw(8'h24, 32'h1);
		chk("bresp", {30'h0, rsp}, {30'h0, `RPS_RESP_SLVERR});
		axw(`RPS_OFF_RAMADDR, 32'h0);
		for (int i = 0; i < 16; i++)
			axw(`RPS_OFF_RAMDATA, ramw(i[9:0]));
		axr(`RPS_OFF_RAMADDR);
		chk("ramaddr", rd, 32'h10);
		// byte lanes: only the two low lanes of the second write may land
		axw(`RPS_PROF_TOP, 32'hffff_ffff);
		s_axi_wstrb <= 4'h3;
		axw(`RPS_PROF_TOP, 32'h0000_1234);
		s_axi_wstrb <= 4'hf;
		axr(`RPS_PROF_TOP);
		chk("wstrb", rd, 32'hffff_1234);
		prof(3'd0, 16'd9, 10'd1, 10'd3);
		prof(3'd2, 16'd1, 10'd4, 10'd6);
		prof(3'd3, 16'd1, 10'd8, 10'd9);
		prof(3'd4, 16'd0, 10'd14, 10'd15);
		prof(3'd5, 16'd3, 10'd10, 10'd12);
		prof(3'd6, 16'd0, 10'd7, 10'd9);
		$display("regs done");
	endtask
	task automatic t_single();
		axw(`RPS_OFF_PROF + 8'h08, 32'h1234_5678);
		pins(3'd1);
		chk("freq tone", freq_word, 32'h1234_5678);
		pins(3'd2);
		chk("freq tone", freq_word, 32'h1);
		axr(`RPS_OFF_STATUS);
		chk("status prof", {29'h0, rd[18:16]}, 32'h2);
		$display("single done");
	endtask
	task automatic t_recirc();
		int c6, c4, cs;
		c6 = 0;
		c4 = 0;
		cs = 0;
		// no-dwell bit set on purpose: it must change nothing
		axw(`RPS_OFF_CTRL, 32'h47);
		upd();
		wait_addr(10'd6);
		for (int k = 0; k < 6; k++) begin
			c6 += int'(ram_addr === 10'd6);
			c4 += int'(ram_addr === 10'd4);
			cs += int'(sweep_over_flag === 1'b1);
			@(posedge aclk);
		end
		chk("dwell", c6, 32'd2);
		chk("reload", c4, 32'd2);
		chk("pulse", cs, 32'd2);
		pins(3'd3);
		wait_addr(10'd8);
		wait_addr(10'd9);
		$display("recirc done");
	endtask
	task automatic t_bidir();
		logic [31:0] w;
		w = ramw(10'd1);
		pins(3'd6);
		axw(`RPS_OFF_CTRL, 32'h3);
		upd();
		repeat (30) @(posedge aclk);
		chk("start", {22'h0, ram_addr}, 32'h1);
		chk("sweep", {31'h0, sweep_over_flag}, 32'h0);
		pins(3'd7);
		wait_addr(10'd3);
		repeat (30) @(posedge aclk);
		chk("halt", {22'h0, ram_addr}, 32'h3);
		chk("sweep", {31'h0, sweep_over_flag}, 32'h1);
		pins(3'd4);
		wait_addr(10'd2);
		pins(3'd5);
		wait_addr(10'd3);
		pins(3'd4);
		wait_addr(10'd1);
		chk("sweep", {31'h0, sweep_over_flag}, 32'h1);
		pins(3'd5);
		chk("sweep", {31'h0, sweep_over_flag}, 32'h0);
		pins(3'd4);
		wait_addr(10'd1);
		for (int d = 0; d < 4; d++) begin
			axw(`RPS_OFF_CTRL, {26'h0, d[1:0], 4'h3});
			upd();
			case (d)
				0: chk("freq", freq_word, w);
				1: chk("phase", {16'h0, phase_word}, {16'h0, w[31:16]});
				2: chk("amp", {18'h0, amp_word}, {18'h0, w[31:18]});
				default: begin
					chk("phase", {16'h0, phase_word}, {16'h0, w[31:16]});
					chk("amp", {18'h0, amp_word}, {18'h0, w[15:2]});
				end
			endcase
		end
		$display("bidir done");
	endtask
	task automatic t_cbidir();
		axw(`RPS_OFF_CTRL, 32'h5);
		pins(3'd5);
		upd();
		wait_addr(10'd12);
		repeat (2) @(posedge aclk);
		chk("sweep", {31'h0, sweep_over_flag}, 32'h1);
		wait_addr(10'd10);
		repeat (2) @(posedge aclk);
		chk("sweep", {31'h0, sweep_over_flag}, 32'h0);
		wait_addr(10'd12);
		pins(3'd4);
		wait_addr(10'd14);
		$display("cbidir done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		t_regs();
		t_single();
		t_recirc();
		t_bidir();
		t_cbidir();
		test_done();
	end
	// watchdog: a hang costs one mismatch
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		test_done();
	end
endmodule
`default_nettype wire
